// [rtl/fp_port_defines.svh]
`ifndef FP_PORT_DEFINES_SVH
`define FP_PORT_DEFINES_SVH

// host microcycle divider and examination length
`define HOST_DIV 8'h04
`define EXAM_CYCLES 2'h2

// host microinstruction codes (values are this block's own encoding)
`define MI_INSTRUCTION_FETCH_MICRO 16'h8001
`define MI_FP_GO 16'h8002
`define MI_NOP 16'h0000
`define MI_READ 16'h4001
`define MI_WRITE 16'h4002
`define MI_COPY_CC 16'h4003
`define MI_SERVICE 16'hC001
`define MI_TRAP 16'hC002
`define TRAP_VECTOR 16'h00A4

// instruction class and op selection fields
`define FP_CLASS 4'hF
`define GRP_MISC 6'h00
`define GRP_LOAD_STATUS 6'h01
`define GRP_STORE_STATUS 6'h02
`define GRP_STORE_EXC 6'h03
`define SUB_COPY_FLAGS 6'h00
`define SUB_SET_SINGLE 6'h01
`define SUB_SET_SHORT 6'h02
`define SUB_SET_DOUBLE 6'h09
`define SUB_SET_LONG 6'h0A

// status register field positions
`define PRECISION_BIT 7
`define INTLEN_BIT 6
`define FLAG_CARRY 0
`define FLAG_OVERFLOW 1
`define FLAG_ZERO 2
`define FLAG_NEGATIVE 3
`define STATUS_RESET 16'h0000

// conversion constants
`define EXP_BIAS_ONE 9'h081
`define SHORT_RANGE 9'h010
`define LONG_RANGE 9'h020

`endif

// [rtl/fp_port_pkg.sv]
package fp_port_pkg;
  typedef enum logic [8:0] {
    ST_MONITOR = 9'h001,
    ST_LATCH = 9'h002,
    ST_EXAMINE = 9'h004,
    ST_DECIDE = 9'h008,
    ST_EXEC = 9'h010,
    ST_ARITH = 9'h020,
    ST_RESYNC = 9'h040,
    ST_SERVICE = 9'h080,
    ST_TRAP = 9'h100
  } port_state_e;

  typedef struct packed {
    logic [5:0] shiftCount;
    logic fractionErr;
    logic rangeErr;
    logic signErr;
  } conv_result_s;
endpackage

// [rtl/conv_check.sv]
`timescale 1ns/1ns
`default_nettype none
`include "fp_port_defines.svh"
module conv_check (
  input wire logic clk, // core clock
  input wire logic reset, // synchronous reset
  input wire logic clear, // start of a new instruction
  input wire logic cvtValid, // conversion operands valid
  input wire logic cvtLong, // long integer target
  input wire logic [7:0] cvtExponent, // biased exponent
  input wire logic cvtSign, // sign of the original value
  input wire logic cvtIntMsb, // msb of converted integer
  output fp_port_pkg::conv_result_s result // registered check results
);
  // test one: exponent minus one-bias, negative means pure fraction
  wire logic [8:0] unbiased = {1'b0, cvtExponent} - `EXP_BIAS_ONE;
  wire logic [8:0] rangeConst = cvtLong ? `LONG_RANGE : `SHORT_RANGE;
  wire logic [8:0] rangeDiff = unbiased - rangeConst;
  // shift count: range + bias - exponent - 1
  wire logic [8:0] shiftSum = rangeConst + `EXP_BIAS_ONE - {1'b0, cvtExponent} - 9'h001;
  wire logic isFraction = unbiased[8];
  // -1 still proceeds; the sign test catches the one bad case
  wire logic outOfRange = !isFraction && !rangeDiff[8];
  wire logic signMismatch = cvtIntMsb != cvtSign;

  // errors stay sticky until engineStart begins the next arithmetic instruction
  always_ff @(posedge clk) begin
    if (reset || clear) begin
      result <= '0;
    end else if (cvtValid) begin
      result.shiftCount <= shiftSum[5:0];
      result.fractionErr <= result.fractionErr | isFraction;
      result.rangeErr <= result.rangeErr | outOfRange;
      result.signErr <= result.signErr | signMismatch;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  chk_long_shift: assert property (cvtValid && !clear && cvtLong |=>
      result.shiftCount == 6'(9'h0A0 - $past({1'b0, cvtExponent})))
    else $error("long shift count wrong");
  chk_sign_flag: assert property (cvtValid && !clear && (cvtIntMsb != cvtSign) |=>
      result.signErr)
    else $error("sign mismatch not flagged");
  chk_no_fraction: assert property (cvtValid && !clear && cvtExponent >= 8'h81
      && !result.fractionErr |=> !result.fractionErr)
    else $error("fraction error without cause");
endmodule // conv_check
`default_nettype wire

// [rtl/fp_coprocessor_handoff_status.sv]
`timescale 1ns/1ns
`default_nettype none
`include "fp_port_defines.svh"
module fp_coprocessor_handoff_status #(
  parameter logic [7:0] HOST_DIV = `HOST_DIV // core clocks per host microcycle
) (
  input wire logic clk, // core clock
  input wire logic reset, // synchronous reset
  input wire logic hostReset, // host reset pin
  input wire logic [15:0] microOpBusIn, // host micro bus pins
  output logic [15:0] microOpBusOut, // micro bus drive value
  output logic microOpBusOe_n, // low while driving micro bus
  output logic microsourceSelect, // we are the micro source
  input wire logic [15:0] sharedDataAddrBusIn, // data bus pins
  output logic [15:0] sharedDataAddrBusOut, // data bus drive value
  output logic sharedDataAddrBusOe_n, // low while driving data bus
  output logic engineStart, // pulse: arithmetic engine go
  input wire logic arithDone, // engine finished
  input wire logic arithError, // engine failed
  input wire logic [15:0] arithErrCode, // engine error code
  input wire logic [3:0] arithErrAddr, // failing instruction address
  input wire logic flagsValid, // engine flag update
  input wire logic [3:0] flagsIn, // new flags n,z,v,c
  input wire logic cvtValid, // conversion operands valid
  input wire logic [7:0] cvtExponent, // biased exponent
  input wire logic cvtSign, // original sign
  input wire logic cvtIntMsb, // converted integer msb
  output logic [5:0] cvtShift, // right shift count
  output logic [15:0] instrLatch, // latched instruction
  output logic [15:0] floatStatus, // status register
  output logic [15:0] floatExceptionCode, // exception code register
  output logic [3:0] floatExceptionAddress, // exception address register
  output logic accWrite, // pulse: accumulator write
  output logic [15:0] accData // accumulator write data
);
  fp_port_pkg::port_state_e state;
  fp_port_pkg::conv_result_s conv;
  logic [15:0] microSync1, microSync2, dataSync1, dataSync2;
  logic hostRst1, hostRst2;
  logic [7:0] divCnt;
  logic tick;
  logic [1:0] step;

  // pins come from the host clock domain: two flops each
  always_ff @(posedge clk) begin
    microSync1 <= microOpBusIn;
    microSync2 <= microSync1;
    dataSync1 <= sharedDataAddrBusIn;
    dataSync2 <= dataSync1;
    hostRst1 <= hostReset;
    hostRst2 <= hostRst1;
  end

  // host microcycle enable; we compute every clk in between
  always_ff @(posedge clk) begin
    if (reset || hostRst2) begin
      divCnt <= 8'h00;
      tick <= 1'b0;
    end else begin
      tick <= (divCnt == HOST_DIV - 8'h01);
      divCnt <= (divCnt == HOST_DIV - 8'h01) ? 8'h00 : divCnt + 8'h01;
    end
  end

  function automatic logic isMisc(input logic [15:0] ins, input logic [5:0] sub);
    isMisc = ins[11:6] == `GRP_MISC && ins[5:0] == sub;
  endfunction

  // opcode decode, valid from the examination cycles onward
  wire logic fpClass = instrLatch[15:12] == `FP_CLASS;
  wire logic opLoadStatus = instrLatch[11:6] == `GRP_LOAD_STATUS;
  wire logic opStoreStatus = instrLatch[11:6] == `GRP_STORE_STATUS;
  wire logic opStoreExc = instrLatch[11:6] == `GRP_STORE_EXC;
  wire logic opCopyFlags = isMisc(instrLatch, `SUB_COPY_FLAGS);
  wire logic opSetSingle = isMisc(instrLatch, `SUB_SET_SINGLE);
  wire logic opSetDouble = isMisc(instrLatch, `SUB_SET_DOUBLE);
  wire logic opSetShort = isMisc(instrLatch, `SUB_SET_SHORT);
  wire logic opSetLong = isMisc(instrLatch, `SUB_SET_LONG);
  wire logic opModeSet = opSetSingle | opSetDouble | opSetShort | opSetLong;
  wire logic opArith = !(opLoadStatus | opStoreStatus | opStoreExc | opCopyFlags | opModeSet);
  wire logic modeZero = instrLatch[5:3] == 3'h0;
  wire logic convFail = conv.fractionErr | conv.rangeErr | conv.signErr;
  wire logic [3:0] hostFlags = {floatStatus[`FLAG_NEGATIVE], floatStatus[`FLAG_ZERO],
                                floatStatus[`FLAG_OVERFLOW], floatStatus[`FLAG_CARRY]};

  conv_check u_conv (
    .clk(clk),
    .reset(reset),
    .clear(engineStart),
    .cvtValid(cvtValid),
    .cvtLong(floatStatus[`INTLEN_BIT]),
    .cvtExponent(cvtExponent),
    .cvtSign(cvtSign),
    .cvtIntMsb(cvtIntMsb),
    .result(conv)
  );
  assign cvtShift = conv.shiftCount;

  // sequencer: host reset jams back to monitoring
  always_ff @(posedge clk) begin
    if (reset || hostRst2) begin
      state <= fp_port_pkg::ST_MONITOR;
      step <= 2'h0;
      instrLatch <= 16'h0000;
    end else begin
      case (state)
        fp_port_pkg::ST_MONITOR: begin
          if (tick && microSync2 == `MI_INSTRUCTION_FETCH_MICRO) state <= fp_port_pkg::ST_LATCH;
        end
        fp_port_pkg::ST_LATCH: begin
          if (tick) begin
            instrLatch <= dataSync2;
            step <= 2'h0;
            state <= fp_port_pkg::ST_EXAMINE;
          end
        end
        fp_port_pkg::ST_EXAMINE: begin
          if (tick) begin
            step <= step + 2'h1;
            if (step + 2'h1 == `EXAM_CYCLES) state <= fp_port_pkg::ST_DECIDE;
          end
        end
        fp_port_pkg::ST_DECIDE: begin
          if (tick) begin
            step <= 2'h0;
            // either verdict is seen here; no go means monitor
            if (microSync2 == `MI_FP_GO && fpClass) state <= fp_port_pkg::ST_EXEC;
            else state <= fp_port_pkg::ST_MONITOR;
          end
        end
        fp_port_pkg::ST_EXEC: begin
          if (tick) begin
            step <= step + 2'h1;
            if (opArith) state <= fp_port_pkg::ST_ARITH;
            else if (opModeSet || opCopyFlags) state <= fp_port_pkg::ST_RESYNC;
            else if ((opLoadStatus || opStoreStatus) && step == 2'h1) state <= fp_port_pkg::ST_RESYNC;
            else if (opStoreExc && (modeZero || step == 2'h2)) state <= fp_port_pkg::ST_RESYNC;
          end
        end
        fp_port_pkg::ST_ARITH: begin
          // runs at core rate; host sees no-ops meanwhile
          if (arithDone) begin
            step <= 2'h0;
            if (arithError || convFail) state <= fp_port_pkg::ST_TRAP;
            else state <= fp_port_pkg::ST_RESYNC;
          end
        end
        fp_port_pkg::ST_RESYNC: begin
          if (tick) state <= fp_port_pkg::ST_SERVICE;
        end
        fp_port_pkg::ST_SERVICE: begin
          if (tick) state <= fp_port_pkg::ST_MONITOR;
        end
        fp_port_pkg::ST_TRAP: begin
          if (tick) begin
            step <= step + 2'h1;
            if (step == 2'h2) state <= fp_port_pkg::ST_MONITOR;
          end
        end
        default: state <= fp_port_pkg::ST_MONITOR;
      endcase
    end
  end

  // what the host sees on the micro bus while we are master
  wire logic master = state == fp_port_pkg::ST_EXEC || state == fp_port_pkg::ST_ARITH
    || state == fp_port_pkg::ST_RESYNC || state == fp_port_pkg::ST_SERVICE
    || (state == fp_port_pkg::ST_TRAP && step != 2'h2);
  wire logic execMove = (opLoadStatus || opStoreStatus) && step == 2'h0;
  wire logic excMove = opStoreExc && !modeZero && step != 2'h2;
  wire logic [15:0] execMicro = (opLoadStatus && step == 2'h0) ? `MI_READ
    : execMove ? `MI_WRITE
    : excMove ? `MI_WRITE
    : opCopyFlags ? (`MI_COPY_CC | {12'h000, hostFlags})
    : `MI_NOP;
  wire logic [15:0] next_micro = (state == fp_port_pkg::ST_EXEC) ? execMicro
    : (state == fp_port_pkg::ST_SERVICE) ? `MI_SERVICE
    : (state == fp_port_pkg::ST_TRAP) ? ((step == 2'h0) ? `MI_TRAP : `TRAP_VECTOR)
    : `MI_NOP;
  wire logic dataDrive = state == fp_port_pkg::ST_EXEC && (execMove && opStoreStatus || excMove);
  wire logic [15:0] next_data = opStoreStatus ? floatStatus
    : (step == 2'h0) ? floatExceptionCode : {12'h000, floatExceptionAddress};

  // bus drivers: micro bus released one clock after we leave mastership, data bus one clock after dataDrive drops
  always_ff @(posedge clk) begin
    if (reset || hostRst2) begin
      microOpBusOut <= `MI_NOP;
      microOpBusOe_n <= 1'b1;
      microsourceSelect <= 1'b0;
      sharedDataAddrBusOut <= 16'h0000;
      sharedDataAddrBusOe_n <= 1'b1;
    end else begin
      microOpBusOut <= next_micro;
      microOpBusOe_n <= !master;
      microsourceSelect <= master;
      sharedDataAddrBusOut <= next_data;
      sharedDataAddrBusOe_n <= !dataDrive;
    end
  end

  wire logic execTick = state == fp_port_pkg::ST_EXEC && tick;

  // status and exception registers
  always_ff @(posedge clk) begin
    if (reset) begin
      floatStatus <= `STATUS_RESET;
      floatExceptionCode <= 16'h0000;
      floatExceptionAddress <= 4'h0;
      engineStart <= 1'b0;
      accWrite <= 1'b0;
      accData <= 16'h0000;
    end else begin
      engineStart <= execTick && opArith;
      accWrite <= execTick && opStoreExc && modeZero;
      accData <= floatExceptionCode;
      if (execTick && opLoadStatus && step == 2'h1) floatStatus <= dataSync2;
      else if (execTick && opSetSingle) floatStatus[`PRECISION_BIT] <= 1'b0;
      else if (execTick && opSetDouble) floatStatus[`PRECISION_BIT] <= 1'b1;
      else if (execTick && opSetShort) floatStatus[`INTLEN_BIT] <= 1'b0;
      else if (execTick && opSetLong) floatStatus[`INTLEN_BIT] <= 1'b1;
      else if (flagsValid) floatStatus[3:0] <= flagsIn;
      // only a failure overwrites; otherwise last error is kept
      if (state == fp_port_pkg::ST_ARITH && arithDone && (arithError || convFail)) begin
        floatExceptionCode <= arithError ? arithErrCode : 16'h0002;
        floatExceptionAddress <= arithErrAddr;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset || hostRst2);
  sequence trapEntry;
    state == fp_port_pkg::ST_TRAP && step == 2'h0 && tick;
  endsequence
  chk_micro_release: assert property (state == fp_port_pkg::ST_MONITOR
      && $past(state) == fp_port_pkg::ST_MONITOR |-> microOpBusOe_n)
    else $error("micro bus driven while monitoring");
  chk_select_tracks_oe: assert property (microsourceSelect == !microOpBusOe_n)
    else $error("select and bus drive disagree");
  chk_trap_vector: assert property (trapEntry |=> microOpBusOut == `MI_TRAP
      ##[1:300] microOpBusOut == `TRAP_VECTOR)
    else $error("trap vector not presented");
  chk_arith_nop: assert property (state == fp_port_pkg::ST_ARITH
      && $past(state) == fp_port_pkg::ST_ARITH |=> microOpBusOut == `MI_NOP)
    else $error("no-op missing during arithmetic");
  chk_fetch_latch: assert property (state == fp_port_pkg::ST_LATCH && tick
      |=> instrLatch == $past(dataSync2))
    else $error("instruction word not latched");
  chk_not_float: assert property (state == fp_port_pkg::ST_DECIDE && tick && !fpClass
      |=> state == fp_port_pkg::ST_MONITOR)
    else $error("non-float instruction taken");
  chk_set_double: assert property (execTick && opSetDouble |=> floatStatus[7])
    else $error("double precision not set");
  chk_set_long: assert property (execTick && opSetLong |=> floatStatus[6])
    else $error("long integer mode not set");
  chk_store_status: assert property (execTick && opStoreStatus && step == 2'h0
      |=> !sharedDataAddrBusOe_n && sharedDataAddrBusOut == $past(floatStatus))
    else $error("status word not driven");
  chk_host_reset: assert property (disable iff (reset) hostRst2
      |=> state == fp_port_pkg::ST_MONITOR)
    else $error("host reset did not force monitoring");
  // hand-over: go verdict, then exec state, then bus and select one clock later
  sequence goVerdict;
    state == fp_port_pkg::ST_DECIDE && tick && microSync2 == `MI_FP_GO && fpClass;
  endsequence
  sequence takeBus;
    state == fp_port_pkg::ST_EXEC ##1 !microOpBusOe_n && microsourceSelect;
  endsequence
  chk_float_takeover: assert property (goVerdict |=> takeBus)
    else $error("float verdict did not hand over the bus");
  chk_load_status: assert property (execTick && opLoadStatus && step == 2'h1
      |=> floatStatus == $past(dataSync2))
    else $error("status word not loaded");
  chk_set_single: assert property (execTick && opSetSingle |=> !floatStatus[7])
    else $error("single precision not selected");
  chk_set_short: assert property (execTick && opSetShort |=> !floatStatus[6])
    else $error("short integer mode not selected");
  chk_exc_capture: assert property (state == fp_port_pkg::ST_ARITH && arithDone
      && arithError |=> floatExceptionCode == $past(arithErrCode)
      && floatExceptionAddress == $past(arithErrAddr))
    else $error("exception registers not loaded");
  chk_data_release: assert property ($past(state) != fp_port_pkg::ST_EXEC
      |-> sharedDataAddrBusOe_n)
    else $error("data bus driven outside execution");
endmodule // fp_coprocessor_handoff_status
`default_nettype wire

// [verification/host_cpu_model.sv]
`timescale 1ns/1ns
`default_nettype none
`include "fp_port_defines.svh"
module host_cpu_model #(
  parameter int HOST_DIV = 4 // core clocks per host microcycle
) (
  input wire logic clk, // core clock
  input wire logic reset, // synchronous reset
  input wire logic [15:0] microOpBusOut, // coprocessor micro drive
  input wire logic microOpBusOe_n, // low while coprocessor drives
  input wire logic microsourceSelect, // coprocessor is micro source
  input wire logic [15:0] sharedDataAddrBusOut, // coprocessor data drive
  input wire logic sharedDataAddrBusOe_n, // low while coprocessor drives
  output logic [15:0] microWire, // resolved micro bus
  output logic [15:0] dataWire // resolved data bus
);
  logic [15:0] hostMicro = 16'h2000;
  logic [15:0] hostData = 16'h0000;
  logic [15:0] memWord = 16'h0000;
  logic [15:0] lastMicro = 16'hFFFF;
  logic [15:0] lastWrite = 16'hFFFF;
  logic hostDataOn = 1'b0;
  logic flip = 1'b0;
  int phase = 0;
  int readHold = 0;
  int stuck = 0; // yield waits that ran out
  logic [15:0] seenMicro[$];
  logic [15:0] seenWrite[$];

  // undriven data bus shows a changing pattern, never a stale word
  assign microWire = !microOpBusOe_n ? microOpBusOut : hostMicro;
  assign dataWire = !sharedDataAddrBusOe_n ? sharedDataAddrBusOut :
    hostDataOn ? hostData : (readHold != 0) ? memWord : (flip ? 16'hA5A5 : 16'h5A5A);

  // host microcycle phase, read answers and traces of what we were told
  always @(posedge clk) begin
    phase <= reset ? 0 : (phase + 1) % HOST_DIV;
    flip <= ~flip;
    readHold <= (microWire == `MI_READ) ? 2 * HOST_DIV
      : (readHold > 0 ? readHold - 1 : 0);
    if (!microOpBusOe_n && microOpBusOut != lastMicro) seenMicro.push_back(microOpBusOut);
    lastMicro <= microOpBusOe_n ? 16'hFFFF : microOpBusOut;
    if (microWire == `MI_WRITE && !sharedDataAddrBusOe_n && sharedDataAddrBusOut != lastWrite)
      seenWrite.push_back(sharedDataAddrBusOut);
    lastWrite <= (microWire == `MI_WRITE && !sharedDataAddrBusOe_n) ? sharedDataAddrBusOut
      : 16'hFFFF;
  end

  // one host microcycle, launched just after a phase-zero edge
  task automatic cycle(input logic [15:0] mi, input logic dOn);
    do begin
      @(posedge clk);
      #1;
    end while (phase != 0);
    hostMicro = mi;
    hostDataOn = dOn;
  endtask

  // fetch, examine, verdict, then yield until the coprocessor lets go
  task automatic run(input logic [15:0] instr, input logic isFloat, input logic [15:0] mem);
    int n;
    seenMicro.delete();
    seenWrite.delete();
    memWord = mem;
    hostData = instr;
    cycle(`MI_INSTRUCTION_FETCH_MICRO, 1'b0);
    cycle(16'h2000, 1'b1);
    cycle(16'h2000, 1'b0);
    cycle(16'h2000, 1'b0);
    cycle(isFloat ? `MI_FP_GO : 16'h2001, 1'b0);
    cycle(isFloat ? ~`MI_FP_GO : 16'h2000, 1'b0);
    // select only rises two clocks into this cycle, so do not look for its fall yet
    repeat (3) @(posedge clk);
    n = 0;
    while (microsourceSelect !== 1'b0 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 4000) stuck++;
    cycle(16'h2000, 1'b0);
  endtask
endmodule // host_cpu_model
`default_nettype wire

// [verification/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
`include "fp_port_defines.svh"
module tb_top;
  localparam int HDIV = 4;
  logic clk = 1'b0, reset = 1'b1, hostReset = 1'b0, arithDone = 1'b0, arithError = 1'b0;
  logic flagsValid = 1'b0, cvtValid = 1'b0, cvtSign = 1'b0, cvtIntMsb = 1'b0;
  logic doCvt = 1'b0, holdEngine = 1'b0, engErr = 1'b0;
  logic [15:0] arithErrCode = 16'h0000, microWire, dataWire, accSeen;
  logic [3:0] arithErrAddr = 4'h0, flagsIn = 4'h0, floatExceptionAddress;
  logic [7:0] cvtExponent = 8'h00;
  logic [15:0] microOpBusOut, sharedDataAddrBusOut, instrLatch, floatStatus;
  logic [15:0] floatExceptionCode, accData;
  logic microOpBusOe_n, microsourceSelect, sharedDataAddrBusOe_n, engineStart, accWrite;
  logic [5:0] cvtShift;
  int err_total = 0, checked = 0, accCount = 0;
  logic [15:0] modeOp[4] = '{16'hF001, 16'hF002, 16'hF009, 16'hF00A};
  logic [15:0] modeExp[4] = '{16'h0045, 16'h0005, 16'h0085, 16'h00C5};
  logic [7:0] cvExp[3] = '{8'h83, 8'hA0, 8'h80};
  logic cvMsb[3] = '{1'b0, 1'b1, 1'b0};
  logic [15:0] cvShift[3] = '{16'h001D, 16'h0000, 16'h0020};
  logic [15:0] cvLast[3] = '{`MI_SERVICE, 16'h00A4, 16'h00A4};
  logic [15:0] cvCode[3] = '{16'h0031, 16'h0002, 16'h0002};

  always #2 clk = ~clk;

  fp_coprocessor_handoff_status #(.HOST_DIV(8'(HDIV))) dut_u (.clk, .reset, .hostReset,
    .microOpBusIn(microWire), .microOpBusOut, .microOpBusOe_n, .microsourceSelect,
    .sharedDataAddrBusIn(dataWire), .sharedDataAddrBusOut, .sharedDataAddrBusOe_n,
    .engineStart, .arithDone, .arithError, .arithErrCode, .arithErrAddr, .flagsValid,
    .flagsIn, .cvtValid, .cvtExponent, .cvtSign, .cvtIntMsb, .cvtShift, .instrLatch,
    .floatStatus, .floatExceptionCode, .floatExceptionAddress, .accWrite, .accData);

  host_cpu_model #(.HOST_DIV(HDIV)) host_u (.clk, .reset, .microOpBusOut, .microOpBusOe_n,
    .microsourceSelect, .sharedDataAddrBusOut, .sharedDataAddrBusOe_n, .microWire,
    .dataWire);

  task automatic check(input logic [15:0] seen, input logic [15:0] expected);
    checked++;
    if (seen !== expected) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, expected);
    end
  endtask

  task automatic results();
    $display("mismatches %0d comparisons %0d", err_total, checked);
    if (err_total == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // engine stand-in: operands after start, done held until control returns
  initial forever begin
    @(posedge clk);
    if (engineStart === 1'b1) begin
      repeat (4) @(posedge clk);
      #1 cvtValid = doCvt;
      @(posedge clk);
      #1 cvtValid = 1'b0;
      repeat (8) @(posedge clk);
      if (!holdEngine) begin
        #1 arithDone = 1'b1;
        arithError = engErr;
        for (int i = 0; i < 400 && microsourceSelect === 1'b1; i++) @(posedge clk);
        #1 arithDone = 1'b0;
        arithError = 1'b0;
      end
    end
  end

  // accumulator writes are single pulses, so catch them as they pass
  always @(posedge clk) if (accWrite === 1'b1) begin
    accSeen <= accData;
    accCount <= accCount + 1;
  end

  // a stuck handshake must not hang the run
  initial begin
    repeat (30000) @(posedge clk);
    err_total++;
    results();
  end

  initial begin
    repeat (2) @(posedge clk);
    #1 reset = 1'b0;
    check(16'(microOpBusOe_n), 16'h0001);
    check(16'(microsourceSelect), 16'h0000);
    host_u.run(16'h1083, 1'b0, 16'h0000);
    check(instrLatch, 16'h1083);
    check(16'(host_u.seenMicro.size()), 16'h0000);
    // float opcode but the host says no: the status word may not change
    host_u.run(16'hF040, 1'b0, 16'h1234);
    check(instrLatch, 16'hF040);
    check(floatStatus, `STATUS_RESET);
    host_u.run(16'hF040, 1'b1, 16'h00C5);
    check(floatStatus, 16'h00C5);
    check(host_u.seenMicro[0], `MI_READ);
    check(host_u.seenMicro[$], `MI_SERVICE);
    check(16'(microOpBusOe_n), 16'h0001);
    host_u.run(16'hF080, 1'b1, 16'h0000);
    check(host_u.seenWrite[0], 16'h00C5);
    for (int i = 0; i < 4; i++) begin
      host_u.run(modeOp[i], 1'b1, 16'h0000);
      check(floatStatus, modeExp[i]);
    end
    @(posedge clk);
    #1 flagsValid = 1'b1;
    flagsIn = 4'hA;
    @(posedge clk);
    #1 flagsValid = 1'b0;
    host_u.run(16'hF000, 1'b1, 16'h0000);
    check(host_u.seenMicro[0], `MI_COPY_CC | 16'h000A);
    check(floatStatus, 16'h00CA);
    engErr = 1'b1;
    arithErrCode = 16'h0031;
    arithErrAddr = 4'h9;
    host_u.run(16'hF400, 1'b1, 16'h0000);
    check(host_u.seenMicro[$-1], `MI_TRAP);
    check(host_u.seenMicro[$], 16'h00A4);
    check(floatExceptionCode, 16'h0031);
    check(16'(floatExceptionAddress), 16'h0009);
    host_u.run(16'hF0C8, 1'b1, 16'h0000);
    check(host_u.seenWrite[0], 16'h0031);
    check(host_u.seenWrite[1], 16'h0009);
    host_u.run(16'hF0C0, 1'b1, 16'h0000);
    check(accSeen, 16'h0031);
    check(16'(accCount), 16'h0001);
    // long-integer conversions: in range, top-bit clash, pure fraction
    engErr = 1'b0;
    doCvt = 1'b1;
    for (int i = 0; i < 3; i++) begin
      cvtExponent = cvExp[i];
      cvtIntMsb = cvMsb[i];
      host_u.run(16'hF400, 1'b1, 16'h0000);
      check(16'(cvtShift), cvShift[i]);
      check(host_u.seenMicro[$], cvLast[i]);
      check(floatExceptionCode, cvCode[i]);
      if (i == 0) check(host_u.seenMicro[$-1], `MI_NOP);
    end
    // host reset while the engine never answers
    doCvt = 1'b0;
    holdEngine = 1'b1;
    fork
      host_u.run(16'hF400, 1'b1, 16'h0000);
      begin
        repeat (40) @(posedge clk);
        #1 hostReset = 1'b1;
        repeat (HDIV + 6) @(posedge clk);
        #1 hostReset = 1'b0;
      end
    join
    holdEngine = 1'b0;
    check(16'(microOpBusOe_n), 16'h0001);
    check(16'(microsourceSelect), 16'h0000);
    host_u.run(16'hF040, 1'b1, 16'h1234);
    check(floatStatus, 16'h1234);
    check(16'(host_u.stuck), 16'h0000);
    results();
  end
endmodule // tb_top
`default_nettype wire
